// ### logic/tss_pkg.sv
// Constants of the tune status sequencer: map, fields, delays.
// Assumes a 100 MHz system clock and a 1 ms delay tick.
package tss_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int T_CLK_NS = 10;            // Clock period
    localparam int T_TICK_NS = 1000000;      // One delay tick, 1 ms
    localparam int TICK_CYC = T_TICK_NS / T_CLK_NS;
    localparam int T_ATTN_MS = 500;          // Attenuator release delay
    localparam int T_FAULT_MS = 1000;        // Mismatch fault delay
    localparam int T_READY_MS = 2000;        // Fine tune delay
    localparam int T_TOUT_MS = 30000;        // Tune cycle limit
    localparam int T_HOME_MS = 7000;         // Homing allowance
    localparam int T_ANT_MS = 10;            // Antenna-mod pulse
    localparam int T_BLINK_MS = 500;         // Half period of blink

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_PRESCALE = 4'h8;

    // Control fields
    localparam int CTRL_TRACK = 0;           // Keep servos on at ready
    localparam int CTRL_GO = 1;              // Write 1: start a tune
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // Status fields
    localparam int ST_READY = 0;
    localparam int ST_FAULT = 1;
    localparam int ST_UNKNOWN = 2;
    localparam int ST_TUNE = 3;
    localparam int ST_HOMING = 4;
    localparam int ST_ATTN = 5;
    localparam int ST_KEY = 6;
    localparam int ST_SERVO = 7;
    localparam int ST_ANT = 8;
    localparam int ST_C_VSWR = 9;
    localparam int ST_C_TOUT = 10;
    localparam int ST_C_HOME = 11;
    localparam int ST_MATCH = 12;
    localparam int ST_RF = 13;

    // ------------------------------------------------------------
    // Synchronised pin vector
    // ------------------------------------------------------------
    localparam int IN_W = 8;
    localparam int IN_TUNE_N = 0;            // Tune initiate, low
    localparam int IN_MATCH = 1;             // Mismatch below 2:1
    localparam int IN_RF = 2;                // rf_power_sufficient
    localparam int IN_C_HOME = 3;            // Capacitor home limit
    localparam int IN_L_HOME = 4;            // Inductor home limit
    localparam int IN_L_MAX = 5;             // Inductor upper limit
    localparam int IN_C_POS = 6;             // Positive phase error
    localparam int IN_INHIB_N = 7;           // Force/retune inhibit
    localparam logic [IN_W-1:0] SYNC_RST = 8'h81;

endpackage

// ### logic/tss_top.sv
// Status and sequencing core of an automatic antenna tuner.
// Assumes pins from comparators and limit switches are
// asynchronous; software talks over Avalon-MM on CLK.
`timescale 1ns/10ps

module tss_top
#(
    parameter logic [31:0] TICK_CYCLES = 32'(tss_pkg::TICK_CYC),
    parameter logic [15:0] READY_TICKS = 16'(tss_pkg::T_READY_MS),
    parameter logic [15:0] FAULT_TICKS = 16'(tss_pkg::T_FAULT_MS),
    parameter logic [15:0] ATTN_TICKS = 16'(tss_pkg::T_ATTN_MS),
    parameter logic [15:0] TOUT_TICKS = 16'(tss_pkg::T_TOUT_MS),
    parameter logic [15:0] HOME_TICKS = 16'(tss_pkg::T_HOME_MS),
    parameter logic [15:0] ANT_TICKS = 16'(tss_pkg::T_ANT_MS),
    parameter logic [15:0] BLINK_TICKS = 16'(tss_pkg::T_BLINK_MS)
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Asynchronous pins
    input wire logic TUNE_INIT_N,
    input wire logic MATCH_OK,
    input wire logic RF_POWER_SUFFICIENT,
    input wire logic C_HOME,
    input wire logic L_HOME,
    input wire logic L_MAX,
    input wire logic C_PHASE_POS,
    input wire logic INHIBIT_N,
    // Indicators and drives
    output logic READY,
    output logic FAULT_LAMP,
    output logic TUNE_ACTIVE,
    output logic ATTN_ON,
    output logic KEY_EN_N,
    output logic SERVO_EN,
    output logic ANT_MOD
);
    import tss_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Delay counter step: zero whenever the condition drops
    function automatic logic [15:0] dly_next(input logic run,
        input logic tk, input logic [15:0] cnt, input logic [15:0] lim);
        logic [15:0] r;
        r = cnt;
        if (!run) begin
            r = 16'h0000;
        end else if (tk && cnt != lim) begin
            r = cnt + 16'h0001;
        end
        return r;
    endfunction

    // One-cycle expiry event of a delay counter
    function automatic logic dly_hit(input logic run, input logic tk,
        input logic [15:0] cnt, input logic [15:0] lim);
        return run && tk && (cnt == lim - 16'h0001);
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [IN_W-1:0] meta_ff;   // First stage, read only below
    logic [IN_W-1:0] pin_ff;    // Safe copy
    logic [IN_W-1:0] prev_ff;   // Last cycle, for edges

    // Two flops, then one more for edge detect
    always_ff @(posedge CLK) begin
        if (RST) begin
            meta_ff <= SYNC_RST;
            pin_ff <= SYNC_RST;
            prev_ff <= SYNC_RST;
        end else begin
            meta_ff <= {INHIBIT_N, C_PHASE_POS, L_MAX, L_HOME, C_HOME,
                RF_POWER_SUFFICIENT, MATCH_OK, TUNE_INIT_N};
            pin_ff <= meta_ff;
            prev_ff <= pin_ff;
        end
    end

    logic match;     // Mismatch below 2:1
    logic rf;        // Enough forward power
    logic silent;    // Silent tune mode
    logic both_home; // Both elements on home limits
    assign match = pin_ff[IN_MATCH];
    assign rf = pin_ff[IN_RF];
    assign silent = !pin_ff[IN_INHIB_N];
    assign both_home = pin_ff[IN_C_HOME] && pin_ff[IN_L_HOME];

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic wait_ff;           // Waitrequest, one low cycle per access
    logic [31:0] rdata_ff;   // Read data
    logic [31:0] ctrl_ff;    // Control register
    logic [31:0] pre_ff;     // Prescaler reload
    logic [31:0] status;     // Live status word
    logic acc;               // Access completes this edge
    logic go_ff;             // Software tune start pulse

    assign acc = (AVS_READ || AVS_WRITE) && !wait_ff;

    // Every access waits exactly one cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !((AVS_READ || AVS_WRITE) && wait_ff);
        end
    end

    // Read mux; unmapped offsets read zero
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_ff <= 32'h0000_0000;
        end else if (AVS_READ && wait_ff) begin
            unique case (AVS_ADDRESS)
                REG_CTRL: rdata_ff <= {30'h0000_0000, 1'b0, ctrl_ff[CTRL_TRACK]};
                REG_STATUS: rdata_ff <= status;
                REG_PRESCALE: rdata_ff <= pre_ff;
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Writes land at the accepting edge; unmapped writes dropped
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_ff <= CTRL_RST;
            pre_ff <= TICK_CYCLES;
            go_ff <= 1'b0;
        end else begin
            go_ff <= 1'b0;
            if (acc && AVS_WRITE) begin
                if (AVS_ADDRESS == REG_CTRL) begin
                    ctrl_ff <= lane_merge(ctrl_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
                    go_ff <= AVS_BYTEENABLE[0] && AVS_WRITEDATA[CTRL_GO];
                end
                if (AVS_ADDRESS == REG_PRESCALE) begin
                    pre_ff <= lane_merge(pre_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
                end
            end
        end
    end

    assign AVS_WAITREQUEST = wait_ff;
    assign AVS_READDATA = rdata_ff;

    // ------------------------------------------------------------
    // Tick prescaler
    // ------------------------------------------------------------
    logic [31:0] pcnt_ff;   // Cycle count within a tick
    logic tick_ff;          // One-cycle tick pulse

    // Zero reload behaves as one, so the tick never stops
    always_ff @(posedge CLK) begin
        if (RST) begin
            pcnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (pcnt_ff + 32'h0000_0001 >= pre_ff) begin
            pcnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            pcnt_ff <= pcnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    logic tune_ff;     // Tune cycle in progress
    logic homing_ff;   // Elements running home
    logic ready_ff;    // Ready latch
    logic fault_ff;    // Fault latch
    logic unk_ff;      // Status unknown since power up
    logic attn_ff;     // Attenuator latch
    logic key_ff;      // Key-enable latch
    logic caway_ff;    // Cap left home on positive phase
    logic ant_ff;      // Antenna-mod pulse active
    logic blink_ff;    // Blink phase
    logic [2:0] cause_ff;   // Vswr, time-out, homing
    logic [15:0] rdy_cnt_ff, flt_cnt_ff, att_cnt_ff;
    logic [15:0] tout_cnt_ff, home_cnt_ff, ant_cnt_ff, blk_cnt_ff;

    // Events
    logic start, rdy_run, flt_run, ready_hit, vfault_ev;
    logic tout_ev, hfail_ev, fault_ev, attn_rel, ready_set;
    logic c_rise, c_fall, lmax_ev, ant_trig;

    // Falling edge of the initiate line; width is the far side's
    assign start = (prev_ff[IN_TUNE_N] && !pin_ff[IN_TUNE_N]) || go_ff;
    assign rdy_run = match && rf;
    assign flt_run = !match && rf;
    assign ready_hit = dly_hit(rdy_run, tick_ff, rdy_cnt_ff, READY_TICKS);
    assign vfault_ev = dly_hit(flt_run, tick_ff, flt_cnt_ff, FAULT_TICKS)
        && !tune_ff;
    assign attn_rel = attn_ff && !homing_ff
        && dly_hit(match, tick_ff, att_cnt_ff, ATTN_TICKS);
    // Normal ready is skipped while a silent tune holds the attenuator
    assign ready_set = (ready_hit && !homing_ff && !(silent && attn_ff))
        || (silent && attn_rel);
    assign tout_ev = dly_hit(tune_ff, tick_ff, tout_cnt_ff, TOUT_TICKS)
        && !ready_set;
    assign hfail_ev = dly_hit(homing_ff, tick_ff, home_cnt_ff, HOME_TICKS);
    assign fault_ev = vfault_ev || tout_ev || hfail_ev;

    // Delay counters, all restart from zero when their cause drops
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdy_cnt_ff <= 16'h0000;
            flt_cnt_ff <= 16'h0000;
            att_cnt_ff <= 16'h0000;
            tout_cnt_ff <= 16'h0000;
            home_cnt_ff <= 16'h0000;
        end else begin
            rdy_cnt_ff <= dly_next(rdy_run, tick_ff, rdy_cnt_ff, READY_TICKS);
            flt_cnt_ff <= dly_next(flt_run, tick_ff, flt_cnt_ff, FAULT_TICKS);
            att_cnt_ff <= dly_next(match, tick_ff, att_cnt_ff, ATTN_TICKS);
            tout_cnt_ff <= dly_next(tune_ff && !start, tick_ff, tout_cnt_ff, TOUT_TICKS);
            home_cnt_ff <= dly_next(homing_ff && !start, tick_ff, home_cnt_ff, HOME_TICKS);
        end
    end

    // Tune cycle: start sets, ready or fault ends
    always_ff @(posedge CLK) begin
        if (RST) begin
            tune_ff <= 1'b0;
        end else if (start) begin
            tune_ff <= 1'b1;
        end else if (ready_set || fault_ev) begin
            tune_ff <= 1'b0;
        end
    end

    // Homing: until both limits made or allowance spent
    always_ff @(posedge CLK) begin
        if (RST) begin
            homing_ff <= 1'b0;
        end else if (start) begin
            homing_ff <= 1'b1;
        end else if (both_home || fault_ev) begin
            homing_ff <= 1'b0;
        end
    end

    // Ready latch; a mismatch fault withdraws it
    always_ff @(posedge CLK) begin
        if (RST) begin
            ready_ff <= 1'b0;
        end else if (ready_set) begin
            ready_ff <= 1'b1;
        end else if (fault_ev || start) begin
            ready_ff <= 1'b0;
        end
    end

    // Fault latch and its cause; the event wins over the clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            fault_ff <= 1'b0;
            cause_ff <= 3'h0;
        end else if (fault_ev) begin
            fault_ff <= 1'b1;
            cause_ff <= {hfail_ev, tout_ev, vfault_ev};
        end else if (start || ready_set) begin
            fault_ff <= 1'b0;
            cause_ff <= 3'h0;
        end
    end

    // Unknown status after power up until anything is known
    always_ff @(posedge CLK) begin
        if (RST) begin
            unk_ff <= 1'b1;
        end else if (start || ready_set || fault_ev) begin
            unk_ff <= 1'b0;
        end
    end

    // Attenuator latch; set wins over release
    always_ff @(posedge CLK) begin
        if (RST) begin
            attn_ff <= 1'b0;
        end else if (start) begin
            attn_ff <= 1'b1;
        end else if (attn_rel) begin
            attn_ff <= 1'b0;
        end
    end

    // Key latch; clearing has priority so ready always unkeys
    always_ff @(posedge CLK) begin
        if (RST) begin
            key_ff <= 1'b0;
        end else if (ready_set || fault_ev) begin
            key_ff <= 1'b0;
        end else if (both_home && tune_ff) begin
            key_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Antenna modification one-shot
    // ------------------------------------------------------------
    assign c_rise = pin_ff[IN_C_HOME] && !prev_ff[IN_C_HOME];
    assign c_fall = !pin_ff[IN_C_HOME] && prev_ff[IN_C_HOME];
    assign lmax_ev = pin_ff[IN_C_HOME] && pin_ff[IN_L_MAX]
        && !(prev_ff[IN_C_HOME] && prev_ff[IN_L_MAX]);
    assign ant_trig = !homing_ff && !ant_ff
        && (lmax_ev || (tune_ff && caway_ff && c_rise));

    // Remember a positive-phase departure from home
    always_ff @(posedge CLK) begin
        if (RST) begin
            caway_ff <= 1'b0;
        end else if (!tune_ff || (c_rise && !homing_ff)) begin
            caway_ff <= 1'b0;
        end else if (c_fall && pin_ff[IN_C_POS]) begin
            caway_ff <= 1'b1;
        end
    end

    // Pulse lasts ANT_TICKS ticks; tick phase costs up to one ms
    always_ff @(posedge CLK) begin
        if (RST) begin
            ant_ff <= 1'b0;
            ant_cnt_ff <= 16'h0000;
        end else begin
            ant_cnt_ff <= dly_next(ant_ff, tick_ff, ant_cnt_ff, ANT_TICKS);
            if (ant_trig) begin
                ant_ff <= 1'b1;
            end else if (dly_hit(ant_ff, tick_ff, ant_cnt_ff, ANT_TICKS)) begin
                ant_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Blink divider
    // ------------------------------------------------------------
    // Free running, so the lamp starts in any phase
    always_ff @(posedge CLK) begin
        if (RST) begin
            blk_cnt_ff <= 16'h0000;
            blink_ff <= 1'b0;
        end else if (dly_hit(1'b1, tick_ff, blk_cnt_ff, BLINK_TICKS)) begin
            blk_cnt_ff <= 16'h0000;
            blink_ff <= !blink_ff;
        end else begin
            blk_cnt_ff <= dly_next(1'b1, tick_ff, blk_cnt_ff, BLINK_TICKS);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic servo_nxt;

    // Homing runs regardless of RF; otherwise RF, no fault, status known, not done unless tracking
    always_comb begin
        if (homing_ff) begin
            servo_nxt = !fault_ev;
        end else begin
            servo_nxt = !fault_ff && !unk_ff && rf
                && (!ready_ff || ctrl_ff[CTRL_TRACK]);
        end
    end

    // All pins leave from flops
    always_ff @(posedge CLK) begin
        if (RST) begin
            READY <= 1'b0;
            FAULT_LAMP <= 1'b1;
            TUNE_ACTIVE <= 1'b0;
            ATTN_ON <= 1'b0;
            KEY_EN_N <= 1'b1;
            SERVO_EN <= 1'b0;
            ANT_MOD <= 1'b0;
        end else begin
            READY <= ready_ff;
            FAULT_LAMP <= unk_ff || (fault_ff && blink_ff);
            TUNE_ACTIVE <= tune_ff;
            ATTN_ON <= attn_ff;
            KEY_EN_N <= !(tune_ff && key_ff);
            SERVO_EN <= servo_nxt;
            ANT_MOD <= ant_ff;
        end
    end

    // Live status word
    always_comb begin
        status = 32'h0000_0000;
        status[ST_READY] = ready_ff;
        status[ST_FAULT] = fault_ff;
        status[ST_UNKNOWN] = unk_ff;
        status[ST_TUNE] = tune_ff;
        status[ST_HOMING] = homing_ff;
        status[ST_ATTN] = attn_ff;
        status[ST_KEY] = key_ff;
        status[ST_SERVO] = SERVO_EN;
        status[ST_ANT] = ant_ff;
        status[ST_C_VSWR] = cause_ff[0];
        status[ST_C_TOUT] = cause_ff[1];
        status[ST_C_HOME] = cause_ff[2];
        status[ST_MATCH] = match;
        status[ST_RF] = rf;
    end

endmodule // tss_top

// ### testbench/tss_checker.sv
// Port checker of the tune status sequencer.
// Assumes it is bound onto tss_top and gets its parameters.
`timescale 1ns/10ps
module tss_checker #(
    parameter logic [31:0] TICK_CYCLES = 32'h4,
    parameter logic [15:0] READY_TICKS = 16'h8,
    parameter logic [15:0] ATTN_TICKS = 16'h3,
    parameter logic [15:0] TOUT_TICKS = 16'h3C
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Pins and drives
    input wire logic TUNE_INIT_N,
    input wire logic MATCH_OK,
    input wire logic RF_POWER_SUFFICIENT,
    input wire logic INHIBIT_N,
    input wire logic READY,
    input wire logic TUNE_ACTIVE,
    input wire logic ATTN_ON,
    input wire logic KEY_EN_N,
    input wire logic ANT_MOD
);
    logic [31:0] mr_cnt; // Cycles of match with RF, raw pins
    logic [31:0] tn_cnt; // Cycles of one tune cycle
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // ------------------------------------------------------------
    // Helper counters; raw pins lead the synchronisers, so mr_cnt over-counts
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        mr_cnt <= (MATCH_OK && RF_POWER_SUFFICIENT) ? mr_cnt + 32'h1 : 32'h0;
        tn_cnt <= TUNE_ACTIVE ? tn_cnt + 32'h1 : 32'h0;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_rst; $fell(RST) |-> !READY && KEY_EN_N && !TUNE_ACTIVE && !ATTN_ON && !ANT_MOD; endproperty
    a_rst: assert property (p_rst) else $error("outputs busy after reset");
    property p_key; !KEY_EN_N |-> TUNE_ACTIVE || $past(TUNE_ACTIVE); endproperty
    a_key: assert property (p_key) else $error("key out of tune");
    property p_rdy; $rose(READY) |-> ##[0:2] !TUNE_ACTIVE && KEY_EN_N; endproperty
    a_rdy: assert property (p_rdy) else $error("tune or key kept at ready");
    property p_ant_w; $rose(ANT_MOD) |-> ANT_MOD[*8]; endproperty
    a_ant_w: assert property (p_ant_w) else $error("antenna pulse short");
    property p_ant_e; $rose(ANT_MOD) |-> ##[36:41] !ANT_MOD; endproperty
    a_ant_e: assert property (p_ant_e) else $error("antenna pulse long");
    property p_start; $fell(TUNE_INIT_N) |-> ##[2:8] TUNE_ACTIVE && ATTN_ON; endproperty
    a_start: assert property (p_start) else $error("start missed");
    property p_tout; tn_cnt <= 32'(TOUT_TICKS) * TICK_CYCLES + 32'h10; endproperty
    a_tout: assert property (p_tout) else $error("tune cycle overran");
    property p_attn; $fell(ATTN_ON) && TUNE_ACTIVE |-> mr_cnt >= (32'(ATTN_TICKS) - 32'h1) * TICK_CYCLES; endproperty
    a_attn: assert property (p_attn) else $error("attenuator out early");
    property p_ready; $rose(READY) && INHIBIT_N |-> mr_cnt >= (32'(READY_TICKS) - 32'h1) * TICK_CYCLES; endproperty
    a_ready: assert property (p_ready) else $error("ready early");
endmodule // tss_checker
bind tss_top tss_checker #(.TICK_CYCLES(TICK_CYCLES), .READY_TICKS(READY_TICKS), .ATTN_TICKS(ATTN_TICKS),
    .TOUT_TICKS(TOUT_TICKS)) u_chk (.CLK, .RST, .TUNE_INIT_N, .MATCH_OK, .RF_POWER_SUFFICIENT, .INHIBIT_N,
    .READY, .TUNE_ACTIVE, .ATTN_ON, .KEY_EN_N, .ANT_MOD);

// ### testbench/tss_partner.sv
// Far side: tuning elements, comparators and exciter RF.
// Assumes mode 2 stops homing and mode 3 stops matching.
`timescale 1ns/10ps
module tss_partner (
    // Clock, reset, bench control
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] mode,
    input wire logic [7:0] home_cyc,
    input wire logic bad_match,
    // From the block
    input wire logic tune_active,
    input wire logic key_en_n,
    // To the block
    output logic match_ok,
    output logic rf_ok,
    output logic c_home,
    output logic l_home
);
    logic [7:0] cnt_ff; // Progress since tune start, saturates
    logic tune_ff;      // Previous tune level
    logic match_ff;     // Network matched
    // Elements leave home at each start and return after home_cyc
    always_ff @(posedge clk) begin
        tune_ff <= tune_active;
        if (rst || (tune_active && !tune_ff)) begin
            cnt_ff <= 8'h00;
            c_home <= 1'b0;
            l_home <= 1'b0;
            match_ff <= 1'b0;
        end else begin
            cnt_ff <= (cnt_ff == 8'hFF) ? cnt_ff : cnt_ff + 8'h01;
            c_home <= !match_ff && (c_home || (cnt_ff == home_cyc && mode != 2'h2));
            l_home <= l_home || (cnt_ff == home_cyc && mode != 2'h2);
            match_ff <= match_ff || (!key_en_n && cnt_ff >= home_cyc + 8'h18 && mode != 2'h3);
        end
    end
    // No RF while unkeyed in a tune cycle; the operator transmits otherwise
    assign rf_ok = !key_en_n || !tune_active;
    assign match_ok = match_ff && !bad_match;
endmodule // tss_partner

// ### testbench/tb_top.sv
// Self-checking bench of the tune status sequencer.
// Assumes short delay parameters and a 4-cycle tick.
`timescale 1ns/10ps
module tb_top;
    import tss_pkg::*;
    logic CLK, RST, AVS_READ, AVS_WRITE, TUNE_INIT_N, L_MAX, C_PHASE_POS, INHIBIT_N, MATCH_OK;
    logic RF_POWER_SUFFICIENT, C_HOME, L_HOME, AVS_WAITREQUEST, READY, FAULT_LAMP, TUNE_ACTIVE;
    logic ATTN_ON, KEY_EN_N, SERVO_EN, ANT_MOD, bad_match;
    logic [3:0] AVS_ADDRESS, AVS_BYTEENABLE;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA;
    logic [1:0] p_mode;
    logic [7:0] home_cyc;
    logic [63:0] exp_q[$]; // Mask and value of each pending read
    int n_mismatch, cmp_count;
    // Rows: inhibit_n, go, far mode, expected status bits 11:0
    logic [15:0] rows[5] = '{16'h8001, 16'h0001, 16'hC081, 16'hA822, 16'hB422};
    tss_top #(.TICK_CYCLES(32'h4), .READY_TICKS(16'h8), .ATTN_TICKS(16'h3),
        .TOUT_TICKS(16'h3C), .HOME_TICKS(16'h14)) u_dut (.CLK, .RST,
        .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
        .TUNE_INIT_N, .MATCH_OK, .RF_POWER_SUFFICIENT, .C_HOME, .L_HOME, .L_MAX, .C_PHASE_POS, .INHIBIT_N,
        .READY, .FAULT_LAMP, .TUNE_ACTIVE, .ATTN_ON, .KEY_EN_N, .SERVO_EN, .ANT_MOD);
    tss_partner u_far (.clk(CLK), .rst(RST), .mode(p_mode), .home_cyc(home_cyc), .bad_match(bad_match),
        .tune_active(TUNE_ACTIVE), .key_en_n(KEY_EN_N), .match_ok(MATCH_OK), .rf_ok(RF_POWER_SUFFICIENT),
        .c_home(C_HOME), .l_home(L_HOME));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // One Avalon access; a read notes {mask, value} for the monitor
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
        input logic [63:0] em);
        int n;
        n = 0;
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        if (!wr) exp_q.push_back(em);
        do begin
            @(posedge CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
        if (n >= 40) begin
            n_mismatch++;
            test_done;
        end
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    // Bounded wait for the antenna pulse or for the tune cycle to end
    task automatic wt(input logic ant, input int lim);
        int n;
        n = 0;
        while ((ant ? ANT_MOD !== 1'b1 : TUNE_ACTIVE !== 1'b0) && n < lim) begin
            @(posedge CLK);
            n++;
        end
        if (n >= lim) begin
            n_mismatch++;
            test_done;
        end
    endtask
    task automatic run_row(input logic [15:0] r);
        @(posedge CLK);
        INHIBIT_N <= r[15];
        p_mode <= r[13:12];
        home_cyc <= 8'($urandom_range(40, 4));
        bus(1'b1, REG_CTRL, {30'h0, r[14], r[14]}, 4'hF, 64'h0);
        if (!r[14]) begin
            TUNE_INIT_N <= 1'b0;
            repeat (4) @(posedge CLK);
            TUNE_INIT_N <= 1'b1;
        end
        repeat (8) @(posedge CLK);
        wt(1'b0, 900);
        bus(1'b0, REG_STATUS, 32'h0, 4'hF, {32'h0000_0EEB, 20'h0, r[11:0]});
    endtask
    // Monitor: each completed read is compared with the oldest note
    always @(posedge CLK) begin
        if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && exp_q.size() > 0) begin
            check(AVS_READDATA & exp_q[0][63:32], exp_q[0][31:0]);
            void'(exp_q.pop_front());
        end
    end
    initial begin
        {AVS_READ, AVS_WRITE, L_MAX, C_PHASE_POS, bad_match, p_mode} = '0;
        {AVS_ADDRESS, AVS_WRITEDATA, home_cyc} = '0;
        {TUNE_INIT_N, INHIBIT_N, RST, AVS_BYTEENABLE} = '1;
        n_mismatch = 0;
        cmp_count = 0;
        void'($urandom(83));
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        bus(1'b0, REG_CTRL, 32'h0, 4'hF, {32'hFFFF_FFFF, 32'h0});
        bus(1'b1, REG_PRESCALE, $urandom(), 4'h0, 64'h0);
        bus(1'b0, REG_PRESCALE, 32'h0, 4'hF, {32'hFFFF_FFFF, 32'h4});
        bus(1'b1, 4'hC, $urandom(), 4'hF, 64'h0);
        bus(1'b0, 4'hC, 32'h0, 4'hF, {32'hFFFF_FFFF, 32'h0});
        bus(1'b1, REG_STATUS, $urandom(), 4'hF, 64'h0);
        bus(1'b0, REG_STATUS, 32'h0, 4'hF, {32'h0000_0005, 32'h0000_0004});
        $display("registers done");
        for (int i = 0; i < 5; i++) begin
            run_row(rows[i]);
            $display("tune row %0d done", i);
        end
        L_MAX <= 1'b1;
        wt(1'b1, 40);
        bus(1'b0, REG_STATUS, 32'h0, 4'hF, {32'h0000_0100, 32'h0000_0100});
        L_MAX <= 1'b0;
        C_PHASE_POS <= 1'b1;
        $display("antenna pulse done");
        run_row(rows[0]);
        bad_match <= 1'b1;
        repeat (8) @(posedge CLK);
        bad_match <= 1'b0;
        repeat (24) @(posedge CLK);
        bus(1'b0, REG_STATUS, 32'h0, 4'hF, {32'h0000_0203, 32'h0000_0001});
        bad_match <= 1'b1;
        repeat (4100) @(posedge CLK);
        bus(1'b0, REG_STATUS, 32'h0, 4'hF, {32'h0000_0203, 32'h0000_0202});
        $display("mismatch fault done");
        test_done;
    end
endmodule // tb_top
